// *** include/spk_consts.svh ***
// Named constants for the stereo pulse-density speaker transmitter.
// Assumes inclusion by bare name from files compiled with include/ on the path.
`ifndef SPK_CONSTS_SVH
`define SPK_CONSTS_SVH

// Register indices; the byte address is four times the index
`define SPK_IDX_MUTE_CTL 12'h490
`define SPK_IDX_FMT_CTL 12'h491
`define SPK_IDX_PATH_CTL 12'h492
`define SPK_IDX_STATUS 12'h493

// Register width and reset values
`define SPK_REG_W 16
`define SPK_MUTE_CTL_RST 16'h0069
`define SPK_FMT_CTL_RST 16'h0000
`define SPK_PATH_CTL_RST 16'h0000

// Writable bit masks; all other bits read as zero
`define SPK_MUTE_CTL_MASK 16'h31FF
`define SPK_FMT_CTL_MASK 16'h0001
`define SPK_PATH_CTL_MASK 16'h001F

// Mute control fields
`define SPK_MUTE_R_BIT 13
`define SPK_MUTE_L_BIT 12
`define SPK_ENDIAN_BIT 8
`define SPK_PAT_MSB 7
`define SPK_PAT_LSB 0
`define SPK_PAT_LAST 3'h7

// Format control field
`define SPK_FMT_BIT 0

// Path control fields
`define SPK_PATH_L_EN_BIT 0
`define SPK_PATH_R_EN_BIT 1
`define SPK_PATH_OSR_BIT 2
`define SPK_PATH_FRAC_BIT 3
`define SPK_PATH_SYSTEM_CLOCK_BIT 4

// Status fields
`define SPK_STAT_RUN_BIT 0
`define SPK_STAT_L_PAT_BIT 1
`define SPK_STAT_R_PAT_BIT 2

// Bit clock rates in Hz and quarter-phase ticks per bit clock period
`define SPK_RATE_NORM_HZ 3072000
`define SPK_RATE_HIGH_HZ 6144000
`define SPK_RATE_NORM_FRAC_HZ 2822400
`define SPK_RATE_HIGH_FRAC_HZ 5644800
`define SPK_QUARTERS 4

`endif

// *** include/spk_pkg.sv ***
// Types shared by the speaker transmitter modules.
// Assumes nothing beyond a SystemVerilog compiler.
package spk_pkg;

  // Quarter phase of the bit clock period
  typedef enum logic [1:0]
  {
    PH_RISE = 2'b00,
    PH_MID_HIGH = 2'b01,
    PH_FALL = 2'b10,
    PH_MID_LOW = 2'b11
  } spk_phase_t;

  // Register selected by an APB address
  typedef enum logic [2:0]
  {
    REG_MUTE = 3'b000,
    REG_FMT = 3'b001,
    REG_PATH = 3'b010,
    REG_STAT = 3'b011,
    REG_NONE = 3'b100
  } spk_reg_t;

endpackage

// *** design/spk_bclk_gen.sv ***
// Quarter-phase tick generator for the speaker bit clock.
// Assumes clk is the system clock and run comes from logic on the same clock.
`timescale 1ns/100ps
`include "spk_consts.svh"

module spk_bclk_gen #(
  parameter int CLK_HZ = 100000000,
  parameter int ACC_W = 24
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Rate selection
  input wire logic run,
  input wire logic osr_high,
  input wire logic frac_family,
  // Phase outputs
  output logic tick,
  output spk_pkg::spk_phase_t phase
);

  // Increment per clk for a tick rate of four times the bit clock
  localparam logic [63:0] INC_NORM =
    ((64'(`SPK_RATE_NORM_HZ) * 64'(`SPK_QUARTERS)) << ACC_W) / 64'(CLK_HZ);
  localparam logic [63:0] INC_HIGH =
    ((64'(`SPK_RATE_HIGH_HZ) * 64'(`SPK_QUARTERS)) << ACC_W) / 64'(CLK_HZ);
  localparam logic [63:0] INC_NORM_FRAC =
    ((64'(`SPK_RATE_NORM_FRAC_HZ) * 64'(`SPK_QUARTERS)) << ACC_W) / 64'(CLK_HZ);
  localparam logic [63:0] INC_HIGH_FRAC =
    ((64'(`SPK_RATE_HIGH_FRAC_HZ) * 64'(`SPK_QUARTERS)) << ACC_W) / 64'(CLK_HZ);

  logic [ACC_W-1:0] acc_r;
  logic [ACC_W-1:0] inc;
  logic [ACC_W:0] sum;

  // Fractional accumulation keeps the average rate exact; the cost is
  // one clk period of edge jitter, since clk is no multiple of the rate.
  always_comb
  begin
    case ({osr_high, frac_family})
      2'b00: inc = INC_NORM[ACC_W-1:0];
      2'b10: inc = INC_HIGH[ACC_W-1:0];
      2'b01: inc = INC_NORM_FRAC[ACC_W-1:0];
      2'b11: inc = INC_HIGH_FRAC[ACC_W-1:0];
      default: inc = INC_NORM[ACC_W-1:0];
    endcase
  end

  assign sum = {1'b0, acc_r} + {1'b0, inc};

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      acc_r <= '0;
      tick <= 1'b0;
      phase <= spk_pkg::PH_MID_LOW;
    end
    else if (!run)
    begin
      acc_r <= '0;
      tick <= 1'b0;
      phase <= spk_pkg::PH_MID_LOW;
    end
    else
    begin
      acc_r <= sum[ACC_W-1:0];
      tick <= sum[ACC_W];
      if (sum[ACC_W])
        phase <= spk_pkg::spk_phase_t'(phase + 2'h1);
    end
  end

endmodule

// *** design/spk_pdm_tx.sv ***
// Stereo pulse-density speaker transmitter with APB register access.
// Assumes clk is the system clock and the audio bits come from logic on clk.
// What this block does
// - Interleave left and right streams on one pin.
// - Format A: left at rise, right at fall.
// - Format B: left in low, right in high.
// - Drive bit clock while either path enabled.
// - Bit clock 3.072 or 6.144 MHz by oversampling.
// - Fractional family scales bit clock proportionally.
// - No clocking without system clock enable set.
// - Independent channel mute; pattern resets to 0x69.
// - Writable 8-bit pattern shared by both channels.
// - Bit 8 picks pattern order, LSB or MSB.
// - Mute switches to pattern immediately, no ramp.
// - Mute bits 13 right, 12 left, reset 0.
// - Format bit 0 of second register, reset A.
//
// Local design decision: the APB register port.
`timescale 1ns/100ps
`include "spk_consts.svh"

module spk_pdm_tx #(
  parameter int CLK_HZ = 100000000,
  parameter int APB_AW = 16,
  parameter int ACC_W = 24
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Audio bit streams from the output paths
  input wire logic left_audio_bit,
  input wire logic right_audio_bit,
  output logic left_audio_take,
  output logic right_audio_take,
  // Speaker pins
  output logic speaker_bit_clock,
  output logic speaker_bitstream_out
);

  localparam int IDX_W = APB_AW - 2;

  // Register state
  logic [`SPK_REG_W-1:0] mute_ctl_r;
  logic [`SPK_REG_W-1:0] fmt_ctl_r;
  logic [`SPK_REG_W-1:0] path_ctl_r;

  // Serializer state
  logic [2:0] left_pat_idx_r;
  logic [2:0] right_pat_idx_r;
  logic running_r;

  // Generator outputs
  logic tick;
  spk_pkg::spk_phase_t phase;

  // Decoded controls
  logic left_mute;
  logic right_mute;
  logic msb_first;
  logic [7:0] pattern;
  logic fmt_b;
  logic left_en;
  logic right_en;
  logic osr_high;
  logic frac_family;
  logic system_clock_en;
  logic run;
  logic left_pat_active;
  logic right_pat_active;

  // Slot timing
  logic rise_evt;
  logic fall_evt;
  logic left_load;
  logic right_load;
  logic left_bit;
  logic right_bit;

  // APB decode
  spk_pkg::spk_reg_t sel;
  logic access;
  logic wr_fire;
  logic [`SPK_REG_W-1:0] wdata16;
  logic [`SPK_REG_W-1:0] rd_val;
  logic [`SPK_REG_W-1:0] status_val;

  // Address to register; misaligned or unmapped addresses give REG_NONE
  function automatic spk_pkg::spk_reg_t reg_decode(input logic [APB_AW-1:0] addr);
    logic [IDX_W-1:0] idx;
    idx = addr[APB_AW-1:2];
    if (addr[1:0] != 2'h0)
      reg_decode = spk_pkg::REG_NONE;
    else if (idx == IDX_W'(`SPK_IDX_MUTE_CTL))
      reg_decode = spk_pkg::REG_MUTE;
    else if (idx == IDX_W'(`SPK_IDX_FMT_CTL))
      reg_decode = spk_pkg::REG_FMT;
    else if (idx == IDX_W'(`SPK_IDX_PATH_CTL))
      reg_decode = spk_pkg::REG_PATH;
    else if (idx == IDX_W'(`SPK_IDX_STATUS))
      reg_decode = spk_pkg::REG_STAT;
    else
      reg_decode = spk_pkg::REG_NONE;
  endfunction

  // Pick pattern bit number idx in the selected order
  function automatic logic pattern_bit(
    input logic [7:0] pat,
    input logic msb,
    input logic [2:0] idx
  );
    logic [2:0] pos;
    pos = msb ? (`SPK_PAT_LAST - idx) : idx;
    pattern_bit = pat[pos];
  endfunction

  // Field extraction
  assign left_mute = mute_ctl_r[`SPK_MUTE_L_BIT];
  assign right_mute = mute_ctl_r[`SPK_MUTE_R_BIT];
  assign msb_first = mute_ctl_r[`SPK_ENDIAN_BIT];
  assign pattern = mute_ctl_r[`SPK_PAT_MSB:`SPK_PAT_LSB];
  assign fmt_b = fmt_ctl_r[`SPK_FMT_BIT];
  assign left_en = path_ctl_r[`SPK_PATH_L_EN_BIT];
  assign right_en = path_ctl_r[`SPK_PATH_R_EN_BIT];
  assign osr_high = path_ctl_r[`SPK_PATH_OSR_BIT];
  assign frac_family = path_ctl_r[`SPK_PATH_FRAC_BIT];
  assign system_clock_en = path_ctl_r[`SPK_PATH_SYSTEM_CLOCK_BIT];

  // Clocking needs the system clock enabled and at least one path on
  assign run = system_clock_en & (left_en | right_en);

  // A disabled path also sends the pattern so the amplifier hears silence
  assign left_pat_active = left_mute | ~left_en;
  assign right_pat_active = right_mute | ~right_en;

  spk_bclk_gen #(
    .CLK_HZ(CLK_HZ),
    .ACC_W(ACC_W)
  ) u_bclk_gen (
    .clk(clk),
    .resetn(resetn),
    .run(run),
    .osr_high(osr_high),
    .frac_family(frac_family),
    .tick(tick),
    .phase(phase)
  );

  // Quarter-phase decode: clock edges at PH_RISE and PH_FALL.
  // Format A changes data mid-phase so each bit is centred on its edge;
  // format B changes data on the edges so each bit fills its phase.
  always_comb
  begin
    rise_evt = 1'b0;
    fall_evt = 1'b0;
    left_load = 1'b0;
    right_load = 1'b0;
    if (tick)
    begin
      case (phase)
        spk_pkg::PH_RISE:
        begin
          rise_evt = 1'b1;
          right_load = fmt_b;
        end
        spk_pkg::PH_MID_HIGH:
        begin
          right_load = ~fmt_b;
        end
        spk_pkg::PH_FALL:
        begin
          fall_evt = 1'b1;
          left_load = fmt_b;
        end
        spk_pkg::PH_MID_LOW:
        begin
          left_load = ~fmt_b;
        end
        default:
        begin
          rise_evt = 1'b0;
        end
      endcase
    end
  end

  // Bit chosen for each slot; mute takes effect on the very next slot
  assign left_bit = left_pat_active ? pattern_bit(pattern, msb_first, left_pat_idx_r)
                                    : left_audio_bit;
  assign right_bit = right_pat_active ? pattern_bit(pattern, msb_first, right_pat_idx_r)
                                      : right_audio_bit;

  // Bit clock pin
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      speaker_bit_clock <= 1'b0;
    else if (!run)
      speaker_bit_clock <= 1'b0;
    else if (rise_evt)
      speaker_bit_clock <= 1'b1;
    else if (fall_evt)
      speaker_bit_clock <= 1'b0;
  end

  // Interleaved data pin
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      speaker_bitstream_out <= 1'b0;
    else if (!run)
      speaker_bitstream_out <= 1'b0;
    else if (left_load)
      speaker_bitstream_out <= left_bit;
    else if (right_load)
      speaker_bitstream_out <= right_bit;
  end

  // Take strobes pace the upstream paths at one bit per slot
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      left_audio_take <= 1'b0;
      right_audio_take <= 1'b0;
    end
    else
    begin
      left_audio_take <= left_load & left_en;
      right_audio_take <= right_load & right_en;
    end
  end

  // Pattern position per channel; restarts at bit 0 whenever audio plays,
  // so each mute begins with a whole pattern
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      left_pat_idx_r <= 3'h0;
    else if (!left_pat_active || !run)
      left_pat_idx_r <= 3'h0;
    else if (left_load)
      left_pat_idx_r <= left_pat_idx_r + 3'h1;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      right_pat_idx_r <= 3'h0;
    else if (!right_pat_active || !run)
      right_pat_idx_r <= 3'h0;
    else if (right_load)
      right_pat_idx_r <= right_pat_idx_r + 3'h1;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      running_r <= 1'b0;
    else
      running_r <= run;
  end

  // APB: one wait state; pready rises in the second access cycle
  assign sel = reg_decode(paddr);
  assign access = psel & penable & ~pready;
  assign wr_fire = psel & penable & pready & pwrite;
  assign wdata16 = pwdata[`SPK_REG_W-1:0];

  // Status is read-only: a write to it completes without error and
  // changes nothing, so software may poll it freely
  always_comb
  begin
    status_val = '0;
    status_val[`SPK_STAT_RUN_BIT] = running_r;
    status_val[`SPK_STAT_L_PAT_BIT] = left_pat_active;
    status_val[`SPK_STAT_R_PAT_BIT] = right_pat_active;
  end

  always_comb
  begin
    case (sel)
      spk_pkg::REG_MUTE: rd_val = mute_ctl_r;
      spk_pkg::REG_FMT: rd_val = fmt_ctl_r;
      spk_pkg::REG_PATH: rd_val = path_ctl_r;
      spk_pkg::REG_STAT: rd_val = status_val;
      default: rd_val = 16'h0000;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= access;
      pslverr <= access & (sel == spk_pkg::REG_NONE);
      if (access && !pwrite)
        prdata <= {16'h0000, rd_val};
      else if (access)
        prdata <= 32'h00000000;
    end
  end

  // Register writes land at the edge that completes the access
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      mute_ctl_r <= `SPK_MUTE_CTL_RST;
    else if (wr_fire && sel == spk_pkg::REG_MUTE)
      mute_ctl_r <= wdata16 & `SPK_MUTE_CTL_MASK;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      fmt_ctl_r <= `SPK_FMT_CTL_RST;
    else if (wr_fire && sel == spk_pkg::REG_FMT)
      fmt_ctl_r <= wdata16 & `SPK_FMT_CTL_MASK;
  end

  // Changing rate while running is allowed; the new rate takes hold on
  // the next clk, inside the quarter in progress, so one bit may be short or long
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      path_ctl_r <= `SPK_PATH_CTL_RST;
    else if (wr_fire && sel == spk_pkg::REG_PATH)
      path_ctl_r <= wdata16 & `SPK_PATH_CTL_MASK;
  end

endmodule

// *** dv/spk_pdm_tx_monitor.sv ***
// Checker for the speaker pins and the APB answers of spk_pdm_tx.
// Assumes rate and format are only changed while the bit clock is off.
`timescale 1ns/100ps
module spk_pdm_tx_monitor #(
  parameter int APB_AW = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Speaker pins
  input wire logic speaker_bit_clock,
  input wire logic speaker_bitstream_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic fmt_r;
  logic [4:0] path_r;
  logic armed_r;
  logic [4:0] cnt_r;
  logic run;
  logic wr;
  logic mapped;
  assign wr = psel && penable && pready && pwrite;
  assign run = path_r[4] && (path_r[0] || path_r[1]);
  assign mapped = paddr[APB_AW-1:4] == (APB_AW-4)'(12'h124) && paddr[1:0] == 2'h0;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fmt_r <= 1'b0;
      path_r <= 5'h00;
    end
    else if (wr && paddr == APB_AW'(16'h1244))
      fmt_r <= pwdata[0];
    else if (wr && paddr == APB_AW'(16'h1248))
      path_r <= pwdata[4:0];
  end

  // Half-period counter; armed at the first bit clock edge, so only whole halves are checked
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_r <= 5'h00;
      armed_r <= 1'b0;
    end
    else if (!run)
    begin
      cnt_r <= 5'h00;
      armed_r <= 1'b0;
    end
    else if ($changed(speaker_bit_clock))
    begin
      cnt_r <= 5'h01;
      armed_r <= 1'b1;
    end
    else if (cnt_r != 5'h1F)
      cnt_r <= cnt_r + 5'h01;
  end

  a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_err_map: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr wrong");
  a_idle_low: assert property (!run [*4] |-> !speaker_bit_clock && !speaker_bitstream_out)
    else $error("pins active while stopped");
  a_clock_start: assert property ($rose(run) |-> ##[1:24] speaker_bit_clock)
    else $error("bit clock did not start");
  a_half_period: assert property (run && armed_r && $changed(speaker_bit_clock)
    |-> cnt_r >= (path_r[2] ? 5'h07 : path_r[3] ? 5'h10 : 5'h0F) &&
    cnt_r <= (path_r[2] ? 5'h0A : path_r[3] ? 5'h13 : 5'h12))
    else $error("bit clock half period off");
  a_fmt_a_mid: assert property (run && armed_r && !fmt_r
    && $changed(speaker_bit_clock) |-> $stable(speaker_bitstream_out))
    else $error("data moved on clock edge");
  a_fmt_b_edge: assert property (run && armed_r && fmt_r
    && $changed(speaker_bitstream_out) |-> $changed(speaker_bit_clock))
    else $error("data moved mid phase");
  c_run: cover property ($rose(run));
  c_fmt_b: cover property (run && armed_r && fmt_r && $changed(speaker_bit_clock));
  c_err: cover property (pready && pslverr);
endmodule

bind spk_pdm_tx spk_pdm_tx_monitor #(.APB_AW(APB_AW)) i_mon (.clk(clk), .resetn(resetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .speaker_bit_clock(speaker_bit_clock), .speaker_bitstream_out(speaker_bitstream_out));

// *** dv/spk_amp_model.sv ***
// Speaker amplifier model: takes the data pin just before each bit clock edge.
// Assumes the bit clock is slow against clk, so every edge is seen.
`timescale 1ns/100ps
module spk_amp_model (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Speaker pins
  input wire logic bclk,
  input wire logic sdata,
  // Captured pair, strobed once per period
  output logic left_bit,
  output logic right_bit,
  output logic pair_stb
);
  logic bclk_r;
  logic sdata_r;

  // The value before the edge suits both formats
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bclk_r <= 1'b0;
      sdata_r <= 1'b0;
      left_bit <= 1'b0;
      right_bit <= 1'b0;
      pair_stb <= 1'b0;
    end
    else
    begin
      bclk_r <= bclk;
      sdata_r <= sdata;
      pair_stb <= bclk_r && !bclk;
      if (!bclk_r && bclk)
        left_bit <= sdata_r;
      if (bclk_r && !bclk)
        right_bit <= sdata_r;
    end
  end
endmodule

// *** dv/testbench.sv ***
// Self-checking bench: registers, clock gating and rates, streams and muting.
// Assumes the amplifier model and the bound checker.
`timescale 1ns/100ps
module testbench;
  localparam logic [15:0] A_MUTE = 16'h1240;
  localparam logic [15:0] A_FMT = 16'h1244;
  localparam logic [15:0] A_PATH = 16'h1248;
  logic clk;
  logic resetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic l_audio;
  logic r_audio;
  logic bclk;
  logic sdata;
  logic l_bit;
  logic r_bit;
  logic pair_stb;
  logic l_take;
  logic r_take;
  logic [31:0] rd;
  logic er;
  int failures;
  int comparisons;
  int l_takes;
  int r_takes;

  spk_pdm_tx i_spk_pdm_tx (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .left_audio_bit(l_audio), .right_audio_bit(r_audio),
    .left_audio_take(l_take), .right_audio_take(r_take), .speaker_bit_clock(bclk),
    .speaker_bitstream_out(sdata));
  spk_amp_model i_spk_amp_model (.clk(clk), .resetn(resetn), .bclk(bclk), .sdata(sdata),
    .left_bit(l_bit), .right_bit(r_bit), .pair_stb(pair_stb));

  // Take pulses are counted all the time; scenarios compare differences
  always @(posedge clk)
  begin
    l_takes <= l_takes + int'(l_take === 1'b1);
    r_takes <= r_takes + int'(r_take === 1'b1);
  end

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Leading edge keeps back-to-back calls from driving psel twice in one step
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check(n < 20, 1);
  endtask

  task automatic rdchk(input logic [15:0] a, input logic [31:0] exp, input logic e);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
    check(er, e);
  endtask

  task automatic pairs(input int k, output int n);
    n = 0;
    while (k > 0 && n < 2000)
    begin
      @(posedge clk);
      n++;
      if (pair_stb === 1'b1)
        k--;
    end
    check(k, 0);
  endtask

  task automatic grab(output logic [7:0] cl, output logic [7:0] cr);
    int n;
    pairs(2, n);
    for (int i = 0; i < 8; i++)
    begin
      pairs(1, n);
      cl[i] = l_bit;
      cr[i] = r_bit;
    end
  endtask

  function automatic logic rot(input logic [7:0] c, input logic [7:0] s);
    logic [15:0] d;
    d = {s, s};
    rot = 1'b0;
    for (int r = 0; r < 8; r++)
      if (c === d[r +: 8])
        rot = 1'b1;
  endfunction

  task automatic t_regs;
    rdchk(16'h124C, 32'h6, 1'b0);
    rdchk(A_MUTE, 32'h69, 1'b0);
    rdchk(A_FMT, 32'h0, 1'b0);
    apb(1'b1, A_MUTE, 32'hFFFF);
    rdchk(A_MUTE, 32'h31FF, 1'b0);
    apb(1'b1, A_FMT, 32'h1);
    rdchk(A_FMT, 32'h1, 1'b0);
    rdchk(16'h1250, 32'h0, 1'b1);
    apb(1'b1, A_MUTE, 32'h69);
  endtask

  task automatic t_off(input logic [31:0] path);
    int k;
    apb(1'b1, A_PATH, path);
    // Pins settle one edge after the write, the model's strobe two more
    repeat (4) @(posedge clk);
    k = 0;
    repeat (200)
    begin
      @(posedge clk);
      if (pair_stb !== 1'b0 || bclk !== 1'b0)
        k++;
    end
    check(k, 0);
  endtask

  task automatic t_rate(input logic [31:0] path, input int hz);
    int n;
    int exp;
    int lt;
    int rt;
    apb(1'b1, A_PATH, 32'h0);
    apb(1'b1, A_PATH, path);
    pairs(1, n);
    lt = l_takes;
    rt = r_takes;
    pairs(16, n);
    exp = 1600000000 / hz;
    check(n >= exp - 2 && n <= exp + 2, 1);
    check(l_takes - lt, path[0] ? 16 : 0);
    check(r_takes - rt, path[1] ? 16 : 0);
    rdchk(16'h124C, {29'h0, ~path[1], ~path[0], 1'b1}, 1'b0);
  endtask

  task automatic t_stream(input logic f, input logic [7:0] pat, input logic a);
    logic [7:0] cl;
    logic [7:0] cr;
    apb(1'b1, A_PATH, 32'h0);
    apb(1'b1, A_FMT, {31'h0, f});
    l_audio <= a;
    r_audio <= ~a;
    apb(1'b1, A_PATH, 32'h13);
    grab(cl, cr);
    check({cl, cr}, {{8{a}}, {8{~a}}});
    // Upstream streams stay steady at a and ~a through both channel mutes
    apb(1'b1, A_MUTE, {16'h0, 8'h10, pat});
    grab(cl, cr);
    check(rot(cl, pat), 1);
    check(cr, {8{~a}});
    apb(1'b1, A_MUTE, {16'h0, 8'h21, pat});
    grab(cl, cr);
    check(cl, {8{a}});
    check(rot(cr, {<<{pat}}), 1);
    apb(1'b1, A_MUTE, 32'h69);
  endtask

  initial
  begin
    failures = 0;
    comparisons = 0;
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0;
    pwdata = 32'h0;
    l_audio = 1'b0;
    r_audio = 1'b0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    t_regs;
    t_off(32'h03);
    t_off(32'h10);
    t_rate(32'h13, 3072000);
    t_rate(32'h17, 6144000);
    t_rate(32'h1A, 2822400);
    t_rate(32'h1D, 5644800);
    t_stream(1'b0, 8'h0B, 1'b1);
    t_stream(1'b1, 8'h37, 1'b0);
    t_off(32'h0);
    end_of_test;
  end

  initial
  begin
    #600000;
    failures++;
    end_of_test;
  end
endmodule
